//--- design/accel_cfg_pkg.sv
// Constants, field positions and carrier types of the accelerometer
// configuration bank.
// Assumes a byte-wide register port driven by the serial front end.
package accel_cfg_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_SAMPLE_COUNT_LOW = 8'h39;
    localparam logic [7:0] ADDR_QUEUE_CONTROL = 8'h3a;
    localparam logic [7:0] ADDR_PIN_ONE_ROUTING = 8'h3b;
    localparam logic [7:0] ADDR_PIN_TWO_ROUTING = 8'h3c;
    localparam logic [7:0] ADDR_SAMPLE_TIMING = 8'h3d;
    localparam logic [7:0] ADDR_EVENT_STATUS = 8'h40;

    // ------------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_SAMPLE_COUNT_LOW = 8'h80;
    localparam logic [7:0] RST_QUEUE_CONTROL = 8'h00;
    localparam logic [7:0] RST_ROUTING = 8'h00;
    localparam logic [7:0] RST_SAMPLE_TIMING = 8'h00;
    localparam logic [7:0] QUEUE_CONTROL_MASK = 8'h3f;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int COUNT_MSB_BIT = 0;
    localparam int MODE_LSB = 1;
    localparam int FORMAT_LSB = 3;
    localparam int POLARITY_BIT = 7;
    localparam int RATE_LSB = 5;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [2:0] FORMAT_ALL = 3'h0;
    localparam logic [2:0] FORMAT_PEAK = 3'h7;
    localparam logic [2:0] AXES_ALL = 3'h7;
    localparam logic [1:0] MODE_BYPASS = 2'h0;
    localparam logic [1:0] MODE_STREAM = 2'h1;
    localparam logic [1:0] MODE_TRIGGER = 2'h2;
    localparam logic [1:0] MODE_OLDEST = 2'h3;
    localparam logic [12:0] RATE_HZ_400 = 13'h0190;
    localparam logic [12:0] RATE_HZ_800 = 13'h0320;
    localparam logic [12:0] RATE_HZ_1600 = 13'h0640;
    localparam logic [12:0] RATE_HZ_3200 = 13'h0c80;
    localparam logic [12:0] RATE_HZ_6400 = 13'h1900;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [11:0] z;
        logic [11:0] y;
        logic [11:0] x;
        logic peak;
    } sample_t;

    typedef struct packed {
        logic [1:0] axis;
        logic [11:0] value;
    } axis_word_t;

    typedef struct packed {
        logic motion_warning;
        logic awake;
        logic activity;
        logic inactivity;
        logic overrun;
        logic queue_ready;
        logic sample_ready;
    } event_in_t;

endpackage : accel_cfg_pkg

//--- design/accel_cfg_bank.sv
// Configuration bank of the accelerometer: sample count, queue format and
// mode, interrupt pin routing and output rate, plus the axis formatter that
// feeds the sample queue through a two-entry buffer.
// Assumes the serial front end, event logic and queue storage run on
// SYS_CLK_I; only the trigger pin arrives from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Nine-bit count: low register plus control bit0.
// - Low count register resets to 0x80.
// - Trigger mode keeps count samples after trigger.
// - Full flag when stored level reaches count.
// - Format field bits 5:3 picks stored axes.
// - Format 111 stores only peak event samples.
// - Mode field bits 2:1 selects queue mode.
// - Routing bits 6:0 enable events per pin.
// - Routing bit7 set makes pin active low.
// - Pin shows OR of all routed events.
// - Pin undriven when nothing routed to it.
// - Pin one order: awake..data ready, bit6..0.
// - Pin two bit5 routes motion warning instead.
// - Timing bits 7:5 codes 0 to 4 select 400 to 6400 Hz, codes 5 to 7 give 0.
// - Status register shows every event, routed or not.
module accel_cfg_bank (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // Register port
    input wire accel_cfg_pkg::reg_req_t REG_REQ_I,
    output logic [7:0] RD_DATA_O,
    // Event sources and queue level
    input wire accel_cfg_pkg::event_in_t EVENTS_I,
    input wire logic [9:0] FIFO_LEVEL_I,
    input wire logic TRIGGER_PIN_I,
    // Sample stream in
    input wire logic SAMPLE_VALID_I,
    input wire accel_cfg_pkg::sample_t SAMPLE_I,
    output logic SAMPLE_READY_O,
    // Axis word stream out
    output logic OUT_VALID_O,
    output accel_cfg_pkg::axis_word_t OUT_WORD_O,
    input wire logic OUT_READY_I,
    // Configuration outputs
    output logic [8:0] SAMPLE_TARGET_O,
    output logic [1:0] QUEUE_MODE_O,
    output logic FIFO_FULL_O,
    output logic [12:0] RATE_HZ_O,
    // Interrupt pins
    output logic IRQ_ONE_O,
    output logic IRQ_ONE_OE_N_O,
    output logic IRQ_TWO_O,
    output logic IRQ_TWO_OE_N_O
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic [2:0] axis_mask(input logic [2:0] fmt);
        // Bit 0 is x, bit 1 is y, bit 2 is z; peak mode stores all three.
        axis_mask = (fmt == accel_cfg_pkg::FORMAT_ALL) ?
            accel_cfg_pkg::AXES_ALL : fmt;
    endfunction : axis_mask

    function automatic logic [1:0] first_axis(input logic [2:0] pend);
        if (pend[0]) begin
            first_axis = 2'h0;
        end else if (pend[1]) begin
            first_axis = 2'h1;
        end else begin
            first_axis = 2'h2;
        end
    endfunction : first_axis

    function automatic logic [12:0] rate_hz(input logic [2:0] code);
        case (code)
            3'h0: rate_hz = accel_cfg_pkg::RATE_HZ_400;
            3'h1: rate_hz = accel_cfg_pkg::RATE_HZ_800;
            3'h2: rate_hz = accel_cfg_pkg::RATE_HZ_1600;
            3'h3: rate_hz = accel_cfg_pkg::RATE_HZ_3200;
            3'h4: rate_hz = accel_cfg_pkg::RATE_HZ_6400;
            default: rate_hz = 13'h0000;
        endcase
    endfunction : rate_hz

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] count_low;
        logic [7:0] queue_ctl;
        logic [7:0] map_one;
        logic [7:0] map_two;
        logic [7:0] timing;
        logic [7:0] status;
        logic [7:0] rd_data;
        logic [12:0] rate;
        logic full;
        logic irq_one;
        logic irq_one_oe_n;
        logic irq_two;
        logic irq_two_oe_n;
        logic trig_meta;
        logic trig_sync;
        logic trig_prev;
        logic triggered;
        logic [8:0] remaining;
        accel_cfg_pkg::sample_t cur;
        logic [2:0] pend;
        logic in_ready;
        logic out_valid;
        accel_cfg_pkg::axis_word_t out_word;
        logic spare_valid;
        accel_cfg_pkg::axis_word_t spare_word;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [8:0] target;
    logic [2:0] fmt;
    logic [1:0] mode;
    logic [7:0] ev_now;
    logic pop;
    logic push;
    logic accept;
    logic keep;
    logic trig_fire;
    logic [1:0] idx;
    accel_cfg_pkg::axis_word_t word;

    assign target = {s_q.queue_ctl[accel_cfg_pkg::COUNT_MSB_BIT],
                     s_q.count_low};
    assign fmt = s_q.queue_ctl[accel_cfg_pkg::FORMAT_LSB +: 3];
    assign mode = s_q.queue_ctl[accel_cfg_pkg::MODE_LSB +: 2];

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;

        // Trigger pin synchroniser; the edge is taken from the second stage and its delayed copy.
        s_d.trig_meta = TRIGGER_PIN_I;
        s_d.trig_sync = s_q.trig_meta;
        s_d.trig_prev = s_q.trig_sync;

        // Live event vector in status layout.
        ev_now = {EVENTS_I.motion_warning, EVENTS_I.awake,
                  EVENTS_I.activity, EVENTS_I.inactivity,
                  EVENTS_I.overrun,
                  (FIFO_LEVEL_I >= {1'b0, target}),
                  EVENTS_I.queue_ready, EVENTS_I.sample_ready};
        s_d.full = ev_now[2];
        s_d.status = ev_now;

        // Pins: OR of routed events, polarity applied, released if unused.
        s_d.irq_one = (|(s_q.map_one[6:0] & ev_now[6:0])) ^
            s_q.map_one[accel_cfg_pkg::POLARITY_BIT];
        s_d.irq_one_oe_n = ~(|s_q.map_one[6:0]);
        s_d.irq_two = (|(s_q.map_two[6:0] &
            {ev_now[6], ev_now[7], ev_now[4:0]})) ^
            s_q.map_two[accel_cfg_pkg::POLARITY_BIT];
        s_d.irq_two_oe_n = ~(|s_q.map_two[6:0]);

        s_d.rate = rate_hz(s_q.timing[accel_cfg_pkg::RATE_LSB +: 3]);

        // Axis formatter feeding the two-entry buffer.
        pop = s_q.out_valid && OUT_READY_I;
        push = (s_q.pend != 3'h0) && !s_q.spare_valid;
        idx = first_axis(s_q.pend);
        word.axis = idx;
        case (idx)
            2'h0: word.value = s_q.cur.x;
            2'h1: word.value = s_q.cur.y;
            default: word.value = s_q.cur.z;
        endcase
        if (push) begin
            s_d.pend = s_q.pend & ~(3'h1 << idx);
        end
        if (pop) begin
            if (s_q.spare_valid) begin
                s_d.out_word = s_q.spare_word;
                s_d.spare_valid = push;
                s_d.spare_word = word;
            end else begin
                s_d.out_valid = push;
                s_d.out_word = word;
            end
        end else if (push) begin
            if (s_q.out_valid) begin
                s_d.spare_valid = 1'b1;
                s_d.spare_word = word;
            end else begin
                s_d.out_valid = 1'b1;
                s_d.out_word = word;
            end
        end

        // Trigger detection arms the post-trigger sample budget.
        trig_fire = (mode == accel_cfg_pkg::MODE_TRIGGER) &&
            !s_q.triggered && s_q.trig_sync && !s_q.trig_prev;
        if (trig_fire) begin
            s_d.triggered = 1'b1;
            s_d.remaining = target;
        end

        // Sample acceptance and the store-or-drop decision.
        accept = SAMPLE_VALID_I && s_q.in_ready;
        keep = (mode != accel_cfg_pkg::MODE_BYPASS) &&
            ((fmt != accel_cfg_pkg::FORMAT_PEAK) || SAMPLE_I.peak) &&
            !((mode == accel_cfg_pkg::MODE_TRIGGER) && s_q.triggered &&
              (s_q.remaining == 9'h000));
        if (accept) begin
            s_d.cur = SAMPLE_I;
            if (keep) begin
                s_d.pend = axis_mask(fmt);
                if (s_q.triggered && (mode == accel_cfg_pkg::MODE_TRIGGER)) begin
                    s_d.remaining = s_q.remaining - 9'h001;
                end
            end
        end
        s_d.in_ready = (s_d.pend == 3'h0);

        // Register writes; writing queue control re-arms the trigger.
        if (REG_REQ_I.wr) begin
            case (REG_REQ_I.addr)
                accel_cfg_pkg::ADDR_SAMPLE_COUNT_LOW: begin
                    s_d.count_low = REG_REQ_I.wdata;
                end
                accel_cfg_pkg::ADDR_QUEUE_CONTROL: begin
                    s_d.queue_ctl = REG_REQ_I.wdata &
                        accel_cfg_pkg::QUEUE_CONTROL_MASK;
                    // A trigger edge in the same cycle as the re-arm wins.
                    s_d.triggered = trig_fire;
                end
                accel_cfg_pkg::ADDR_PIN_ONE_ROUTING: begin
                    s_d.map_one = REG_REQ_I.wdata;
                end
                accel_cfg_pkg::ADDR_PIN_TWO_ROUTING: begin
                    s_d.map_two = REG_REQ_I.wdata;
                end
                accel_cfg_pkg::ADDR_SAMPLE_TIMING: begin
                    s_d.timing = REG_REQ_I.wdata;
                end
                default: begin
                end
            endcase
        end

        // Register reads answer one cycle later; unmapped reads give zero.
        if (REG_REQ_I.rd) begin
            case (REG_REQ_I.addr)
                accel_cfg_pkg::ADDR_SAMPLE_COUNT_LOW: s_d.rd_data = s_q.count_low;
                accel_cfg_pkg::ADDR_QUEUE_CONTROL: s_d.rd_data = s_q.queue_ctl;
                accel_cfg_pkg::ADDR_PIN_ONE_ROUTING: s_d.rd_data = s_q.map_one;
                accel_cfg_pkg::ADDR_PIN_TWO_ROUTING: s_d.rd_data = s_q.map_two;
                accel_cfg_pkg::ADDR_SAMPLE_TIMING: s_d.rd_data = s_q.timing;
                accel_cfg_pkg::ADDR_EVENT_STATUS: s_d.rd_data = s_q.status;
                default: s_d.rd_data = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            s_q <= '0;
            s_q.count_low <= accel_cfg_pkg::RST_SAMPLE_COUNT_LOW;
            s_q.queue_ctl <= accel_cfg_pkg::RST_QUEUE_CONTROL;
            s_q.map_one <= accel_cfg_pkg::RST_ROUTING;
            s_q.map_two <= accel_cfg_pkg::RST_ROUTING;
            s_q.timing <= accel_cfg_pkg::RST_SAMPLE_TIMING;
            s_q.rate <= accel_cfg_pkg::RATE_HZ_400;
            s_q.irq_one_oe_n <= 1'b1;
            s_q.irq_two_oe_n <= 1'b1;
            s_q.in_ready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign RD_DATA_O = s_q.rd_data;
    assign SAMPLE_READY_O = s_q.in_ready;
    assign OUT_VALID_O = s_q.out_valid;
    assign OUT_WORD_O = s_q.out_word;
    assign SAMPLE_TARGET_O = target;
    assign QUEUE_MODE_O = mode;
    assign FIFO_FULL_O = s_q.full;
    assign RATE_HZ_O = s_q.rate;
    assign IRQ_ONE_O = s_q.irq_one;
    assign IRQ_ONE_OE_N_O = s_q.irq_one_oe_n;
    assign IRQ_TWO_O = s_q.irq_two;
    assign IRQ_TWO_OE_N_O = s_q.irq_two_oe_n;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (RST_I);

    sequence s_ctl_write;
        REG_REQ_I.wr && (REG_REQ_I.addr == accel_cfg_pkg::ADDR_QUEUE_CONTROL);
    endsequence

    property p_target_msb;
        s_ctl_write |=> (SAMPLE_TARGET_O[8] == $past(REG_REQ_I.wdata[0]));
    endproperty
    a_target_msb: assert property (p_target_msb)
        else $error("Sample target top bit not taken from control bit 0.");

    property p_count_reset;
        $fell(RST_I) |-> (s_q.count_low == 8'h80);
    endproperty
    a_count_reset: assert property (p_count_reset)
        else $error("Low sample count not 0x80 after reset.");

    property p_trig_budget;
        trig_fire |=> (s_q.remaining == $past(target)) ##0 s_q.triggered;
    endproperty
    a_trig_budget: assert property (p_trig_budget)
        else $error("Trigger did not load the sample budget.");

    property p_trig_exhausted;
        (s_q.triggered && (s_q.remaining == 9'h000) && accept &&
            (mode == accel_cfg_pkg::MODE_TRIGGER)) |=> (s_q.pend == 3'h0);
    endproperty
    a_trig_exhausted: assert property (p_trig_exhausted)
        else $error("Sample stored after trigger budget ran out.");

    property p_full_flag;
        ##1 (FIFO_FULL_O == $past(FIFO_LEVEL_I >= {1'b0, target}));
    endproperty
    a_full_flag: assert property (p_full_flag)
        else $error("Full flag does not follow level against target.");

    property p_format_axes;
        (accept && keep) |=> (s_q.pend == axis_mask($past(fmt)));
    endproperty
    a_format_axes: assert property (p_format_axes)
        else $error("Stored axes do not match the format field.");

    property p_peak_only;
        (accept && (fmt == 3'h7) && !SAMPLE_I.peak) |=> (s_q.pend == 3'h0);
    endproperty
    a_peak_only: assert property (p_peak_only)
        else $error("Non-peak sample stored in peak format.");

    property p_bypass;
        (accept && (mode == 2'h0)) |=> (s_q.pend == 3'h0) ##1 !OUT_VALID_O ||
            $past(s_q.out_valid);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("Sample stored while queue is bypassed.");

    property p_pin_one;
        ##1 (IRQ_ONE_O == $past((|(s_q.map_one[6:0] & ev_now[6:0])) ^
            s_q.map_one[7]));
    endproperty
    a_pin_one: assert property (p_pin_one)
        else $error("Pin one level is not the routed OR with polarity.");

    property p_pin_two_warning;
        (s_q.map_two == 8'h20) && EVENTS_I.motion_warning |=>
            IRQ_TWO_O && !IRQ_TWO_OE_N_O;
    endproperty
    a_pin_two_warning: assert property (p_pin_two_warning)
        else $error("Motion warning not routed by pin two bit 5.");

    property p_pin_release;
        (s_q.map_one[6:0] == 7'h00) |=> IRQ_ONE_OE_N_O;
    endproperty
    a_pin_release: assert property (p_pin_release)
        else $error("Pin one driven with nothing routed.");

    property p_rate;
        (s_q.timing[7:5] == 3'h4) |=> (RATE_HZ_O == 13'h1900);
    endproperty
    a_rate: assert property (p_rate)
        else $error("Rate code 100 does not give 6400 Hz.");

    property p_status_read;
        (REG_REQ_I.rd && (REG_REQ_I.addr == accel_cfg_pkg::ADDR_EVENT_STATUS))
            |=> (RD_DATA_O == $past(s_q.status));
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("Status read does not return the event vector.");

endmodule : accel_cfg_bank

`default_nettype wire

//--- verification/stream_sink.sv
// Far-side model of the axis word stream: takes words and records them.
// Assumes the testbench selects stalling or slow acceptance through inputs.
`timescale 1ns/1ps
`default_nettype none

module stream_sink (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Stream
    input wire logic valid_i,
    input wire accel_cfg_pkg::axis_word_t word_i,
    output logic ready_o,
    // Behaviour select
    input wire logic stall_i,
    input wire logic slow_i
);
    accel_cfg_pkg::axis_word_t words[$];
    logic toggle_q;

    assign ready_o = !stall_i && (!slow_i || toggle_q);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            toggle_q <= 1'b0;
        end else begin
            toggle_q <= !toggle_q;
            if (valid_i && ready_o) begin
                words.push_back(word_i);
            end
        end
    end
endmodule : stream_sink

`default_nettype wire

//--- verification/test_fifo_irq_map_rate_config.sv
// Self-checking bench of the configuration bank and its axis formatter.
// Assumes the package and bank are compiled first, and the stream sink.
`timescale 1ns/1ps
`default_nettype none

module test_fifo_irq_map_rate_config;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    accel_cfg_pkg::reg_req_t req = '0;
    accel_cfg_pkg::event_in_t events = '0;
    logic [9:0] level = '0;
    logic trig = 1'b0;
    logic s_valid = 1'b0;
    accel_cfg_pkg::sample_t smp = '0;
    logic stall = 1'b0;
    logic slow = 1'b1;
    logic [7:0] rd_data;
    logic s_ready, o_valid, o_ready, full, irq1, oe1_n, irq2, oe2_n;
    accel_cfg_pkg::axis_word_t o_word;
    logic [8:0] target;
    logic [1:0] qmode;
    logic [12:0] rate;
    int errors = 0;
    int n_checks = 0;

    always #4 sys_clk = !sys_clk;

    accel_cfg_bank i_accel_cfg_bank (.SYS_CLK_I(sys_clk), .RST_I(rst),
        .REG_REQ_I(req), .RD_DATA_O(rd_data), .EVENTS_I(events),
        .FIFO_LEVEL_I(level), .TRIGGER_PIN_I(trig),
        .SAMPLE_VALID_I(s_valid), .SAMPLE_I(smp), .SAMPLE_READY_O(s_ready),
        .OUT_VALID_O(o_valid), .OUT_WORD_O(o_word), .OUT_READY_I(o_ready),
        .SAMPLE_TARGET_O(target), .QUEUE_MODE_O(qmode),
        .FIFO_FULL_O(full), .RATE_HZ_O(rate), .IRQ_ONE_O(irq1),
        .IRQ_ONE_OE_N_O(oe1_n), .IRQ_TWO_O(irq2), .IRQ_TWO_OE_N_O(oe2_n));

    stream_sink i_stream_sink (.clk_i(sys_clk), .rst_i(rst),
        .valid_i(o_valid), .word_i(o_word), .ready_o(o_ready),
        .stall_i(stall), .slow_i(slow));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic print_verdict();
        if (errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk);
        req <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge sys_clk);
        req <= '0;
        @(posedge sys_clk);
        #1 chk("read data", {8'h00, exp}, {8'h00, rd_data});
    endtask : rd

    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic send(input logic [2:0] f, input logic peak);
        int k;
        @(posedge sys_clk);
        s_valid <= 1'b1;
        smp <= '{12'h300 + f, 12'h200 + f, 12'h100 + f, peak};
        for (k = 0; k < 50; k++) begin
            @(posedge sys_clk);
            if (s_ready) break;
        end
        s_valid <= 1'b0;
    endtask : send

    task automatic expect_words(input logic [2:0] mask, input logic [2:0] f);
        int a;
        repeat (20) @(posedge sys_clk);
        chk("word count", 16'($countones(mask)),
            16'(i_stream_sink.words.size()));
        for (a = 0; a < 3; a++) begin
            if (mask[a] && i_stream_sink.words.size() > 0) begin
                chk("word", {2'b00, 2'(a), 12'(12'h100 * (a + 1) + f)},
                    {2'b00, i_stream_sink.words.pop_front()});
            end
        end
        i_stream_sink.words.delete();
    endtask : expect_words

    function automatic accel_cfg_pkg::event_in_t ev_for(int pin, int b);
        accel_cfg_pkg::event_in_t e = '0;
        case (b)
            6: e.awake = 1'b1;
            5: if (pin == 1) e.activity = 1'b1; else e.motion_warning = 1'b1;
            4: e.inactivity = 1'b1;
            3: e.overrun = 1'b1;
            1: e.queue_ready = 1'b1;
            0: e.sample_ready = 1'b1;
            default: e = '0;
        endcase
        return e;
    endfunction : ev_for

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        print_verdict();
    end

    initial begin
        int p, b, c;
        logic [7:0] ma;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h39, 8'h80);
        rd(8'h3a, 8'h00);
        rd(8'h3b, 8'h00);
        rd(8'h3c, 8'h00);
        rd(8'h3d, 8'h00);
        rd(8'h50, 8'h00);
        #1 chk("undriven pin", 16'h3, {oe2_n, oe1_n});
        wr(8'h3a, 8'hff);
        rd(8'h3a, 8'h3f);
        wr(8'h39, 8'h05);
        settle();
        chk("target", 16'h105, {7'h00, target});
        level <= 10'h104;
        settle();
        chk("full below", 16'h0, {15'h0, full});
        level <= 10'h105;
        settle();
        chk("full at", 16'h1, {15'h0, full});
        for (c = 0; c < 4; c++) begin
            wr(8'h3a, 8'(c << 1));
            settle();
            chk("mode", 16'(c), {14'h0, qmode});
        end
        for (c = 0; c < 5; c++) begin
            wr(8'h3d, 8'(c << 5) | 8'h1f);
            settle();
            chk("rate", 16'(400 << c), {3'h0, rate});
            rd(8'h3d, 8'(c << 5) | 8'h1f);
        end
        for (p = 1; p < 3; p++) begin
            ma = (p == 1) ? 8'h3b : 8'h3c;
            for (b = 0; b < 7; b++) begin
                wr(ma, 8'(1 << b));
                events <= ev_for(p, b);
                level <= (b == 2) ? 10'h3ff : 10'h000;
                settle();
                chk("pin on", 16'h1, {15'h0, p == 1 ? irq1 : irq2});
                chk("pin drive", 16'h0, {15'h0, p == 1 ? oe1_n : oe2_n});
                events <= ~ev_for(p, b);
                level <= 10'h000;
                settle();
                chk("pin off", 16'h0, {15'h0, p == 1 ? irq1 : irq2});
            end
            wr(ma, 8'h83);
            events <= '0;
            settle();
            chk("low idle", 16'h1, {15'h0, p == 1 ? irq1 : irq2});
            events <= 7'h02;
            settle();
            chk("low active", 16'h0, {15'h0, p == 1 ? irq1 : irq2});
            wr(ma, 8'h00);
        end
        events <= 7'h55;
        level <= 10'h3ff;
        settle();
        rd(8'h40, 8'had);
        events <= '0;
        level <= '0;
        for (c = 0; c < 7; c++) begin
            wr(8'h3a, 8'(c << 3) | 8'h02);
            send(3'(c), 1'b0);
            expect_words(c == 0 ? 3'h7 : 3'(c), 3'(c));
        end
        wr(8'h3a, 8'h3a);
        send(3'h1, 1'b0);
        expect_words(3'h0, 3'h1);
        send(3'h2, 1'b1);
        expect_words(3'h7, 3'h2);
        wr(8'h3a, 8'h00);
        send(3'h3, 1'b0);
        expect_words(3'h0, 3'h3);
        wr(8'h3a, 8'h02);
        stall <= 1'b1;
        send(3'h4, 1'b0);
        repeat (10) @(posedge sys_clk);
        chk("stalled", 16'h0, 16'(i_stream_sink.words.size()));
        chk("ready stalled", 16'h0, {15'h0, s_ready});
        stall <= 1'b0;
        expect_words(3'h7, 3'h4);
        wr(8'h39, 8'h02);
        wr(8'h3a, 8'h0c);
        trig <= 1'b1;
        repeat (5) @(posedge sys_clk);
        trig <= 1'b0;
        send(3'h1, 1'b0);
        expect_words(3'h1, 3'h1);
        send(3'h1, 1'b0);
        expect_words(3'h1, 3'h1);
        send(3'h1, 1'b0);
        expect_words(3'h0, 3'h1);
        print_verdict();
    end
endmodule : test_fifo_irq_map_rate_config

`default_nettype wire
